// >>> rtl/sync_status_and_irq_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "sync_regs_cfg.svh"
module sync_status_and_irq_regs
  import sync_regs_pkg::*;
(
  input  wire logic            clk,        // System clock, 50 MHz.
  input  wire logic            sys_rst,    // Synchronous reset, high.
  input  wire reg_req_t        req,        // Register access request.
  output logic [7:0]           rdata_ff,   // Read data.
  output logic                 rvalid_ff,  // Read data valid pulse.
  input  wire sync_primary_t   sync_pri,   // Live sync engine state.
  input  wire sync_secondary_t sync_sec,   // Live sync engine state.
  input  wire logic [6:0]      evt_src,    // Ready/error events, bits 7..1.
  input  wire logic [2:0]      mon_val,    // Data clock monitor position.
  output logic [1:0]           drift_range_ff, // Drift threshold to monitor.
  output logic                 irq_ff      // Interrupt output, high.
);
  logic [7:0] ctrl_ff;
  logic [7:0] en_ff;
  logic [7:0] flags;
  logic       drift;
  logic       clr_ff;
  logic [7:0] nxt_rdata;
  logic       irq_on;

  assign irq_on = ctrl_ff[`CTRL_EN_BIT];

  // Control and enable writes; status addresses take no write at all.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_ff <= `CTRL_RESET;
      en_ff   <= `EN_RESET;
    end
    else if (req.wr)
    begin
      if (req.addr == `ADDR_IRQ_CTRL)
        ctrl_ff <= req.wdata;
      if (req.addr == `ADDR_IRQ_EN)
        en_ff <= req.wdata;
    end
  end

  // Drift threshold goes out to the monitor as a registered copy.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      drift_range_ff <= 2'h0;
    else
      drift_range_ff <= ctrl_ff[1:0];
  end

  drift_detect u_drift
  (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .range_sel (ctrl_ff[1:0]),
    .mon_val   (mon_val),
    .drift_ff  (drift)
  );

  // Flags clear after being read, but only when clearance is enabled.
  // The clear is gated again at the flags, so a pending clear dies if control drops.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      clr_ff <= 1'b0;
    else
      clr_ff <= req.rd && (req.addr == `ADDR_IRQ_FLAGS) && irq_on;
  end

  // One sticky flag per source, set whatever its enable bit; the enable bit masks only the interrupt.
  for (genvar i = 0; i < 8; i++)
  begin : g_flag
    flag_bit u_flag
    (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .event_in ((i == `FLAG_DRIFT_BIT) ? drift : evt_src[(i == 0) ? 0 : i - 1]),
      .clr      (clr_ff && irq_on),
      .flag_ff  (flags[i])
    );
  end

  // Read multiplexer; status reads are live engine state.
  always_comb
  begin
    case (req.addr)
      `ADDR_SYNC_PRI:  nxt_rdata = sync_pri;
      `ADDR_SYNC_SEC:  nxt_rdata = {2'b00, sync_sec[5:0]};
      `ADDR_IRQ_CTRL:  nxt_rdata = {4'h0, ctrl_ff[3:0]};
      `ADDR_IRQ_EN:    nxt_rdata = en_ff;
      `ADDR_IRQ_FLAGS: nxt_rdata = flags;
      default:         nxt_rdata = `ZERO_BYTE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdata_ff  <= `ZERO_BYTE;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= req.rd;
      if (req.rd)
        rdata_ff <= nxt_rdata;
    end
  end

  // Interrupt is the OR of enabled flags, gated by the control bit.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq_ff <= 1'b0;
    else
      irq_ff <= irq_on && |(flags & en_ff);
  end

  irq_assert_a: assert property (@(posedge clk) disable iff (sys_rst)
    (irq_on && |(flags & en_ff)) |=> irq_ff) else $error("irq missed");
  irq_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    !irq_on |=> !irq_ff) else $error("irq while disabled");
  pri_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    (req.rd && req.addr == `ADDR_SYNC_PRI) |=> rdata_ff == $past(sync_pri))
    else $error("primary status wrong");
  sec_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    (req.rd && req.addr == `ADDR_SYNC_SEC) |=> rdata_ff[5:2] == $past(sync_sec[5:2]))
    else $error("secondary status wrong");
  en_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    (req.wr && req.addr == `ADDR_IRQ_EN) |=> en_ff == $past(req.wdata))
    else $error("enable write lost");
  flag_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    (req.rd && req.addr == `ADDR_IRQ_FLAGS) |=> rdata_ff == $past(flags))
    else $error("flag read wrong");
  flag_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!irq_on && flags[1]) |=> flags[1]) else $error("flag cleared while disabled");
  irq_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
    (en_ff == 8'h00) |=> !irq_ff) else $error("masked irq");
endmodule : sync_status_and_irq_regs
`default_nettype wire

// >>> rtl/sync_regs_cfg.svh
`ifndef SYNC_REGS_CFG_SVH
`define SYNC_REGS_CFG_SVH
`define ADDR_SYNC_PRI   7'h09
`define ADDR_SYNC_SEC   7'h0a
`define ADDR_IRQ_CTRL   7'h0b
`define ADDR_IRQ_EN     7'h0c
`define ADDR_IRQ_FLAGS  7'h0d
`define CTRL_EN_BIT     3
`define CTRL_RANGE_HI   2
`define CTRL_RANGE_LO   0
`define RANGE_SMALL     2'h0
`define RANGE_LARGE     2'h1
`define RANGE_MAX       2'h2
`define MON_SMALL_A     3'h1
`define MON_SMALL_B     3'h5
`define MON_LARGE_A     3'h2
`define MON_LARGE_B     3'h4
`define MON_MAX         3'h3
`define FLAG_DRIFT_BIT  0
`define CTRL_RESET      8'h00
`define EN_RESET        8'h00
`define ZERO_BYTE       8'h00
`endif

// >>> rtl/sync_regs_pkg.sv
package sync_regs_pkg;
  // Live state of the synchronisation engine, packed in register bit order.
  typedef struct packed {
    logic early;
    logic late;
    logic equal;
    logic locked;
    logic max_stop;
    logic min_stop;
    logic match_detected;
    logic eval_active;
  } sync_primary_t;
  typedef struct packed {
    logic [1:0] spare;
    logic       offset_err;
    logic [1:0] en_phase;
    logic       prerun_active;
    logic       lockout;
    logic       lock_flag;
  } sync_secondary_t;
  // One register access from the serial control interface.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage : sync_regs_pkg

// >>> rtl/drift_detect.sv
`timescale 1ns/100ps
`default_nettype none
`include "sync_regs_cfg.svh"
module drift_detect
  import sync_regs_pkg::*;
(
  input  wire logic       clk,       // System clock.
  input  wire logic       sys_rst,   // Synchronous reset, high.
  input  wire logic [1:0] range_sel, // Drift threshold code.
  input  wire logic [2:0] mon_val,   // Clock monitor position.
  output logic            drift_ff   // Registered drift event.
);
  logic nxt_drift;
  // Compare the monitor position with the selected threshold.
  always_comb
  begin
    case (range_sel)
      `RANGE_SMALL: nxt_drift = (mon_val == `MON_SMALL_A) || (mon_val == `MON_SMALL_B);
      `RANGE_LARGE: nxt_drift = (mon_val == `MON_LARGE_A) || (mon_val == `MON_LARGE_B);
      `RANGE_MAX:   nxt_drift = (mon_val == `MON_MAX);
      default:      nxt_drift = 1'b0;
    endcase
  end
  // Registered so the flag register sees a clean level.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      drift_ff <= 1'b0;
    else
      drift_ff <= nxt_drift;
  end
  drift_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    (range_sel == 2'h3) |=> !drift_ff) else $error("drift flag raised while disabled");
endmodule : drift_detect
`default_nettype wire

// >>> rtl/flag_bit.sv
`timescale 1ns/100ps
`default_nettype none
module flag_bit
(
  input  wire logic clk,      // System clock.
  input  wire logic sys_rst,  // Synchronous reset, high.
  input  wire logic event_in, // Ready or error event level.
  input  wire logic clr,      // Clearance pulse.
  output logic      flag_ff   // Sticky flag.
);
  // A set in the clearing cycle wins so no event is lost.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      flag_ff <= 1'b0;
    else if (event_in)
      flag_ff <= 1'b1;
    else if (clr)
      flag_ff <= 1'b0;
  end
endmodule : flag_bit
`default_nettype wire

// >>> tb/sync_status_and_irq_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sync_status_and_irq_regs_tb
  import sync_regs_pkg::*;
;
  logic            clk;
  logic            sys_rst;
  reg_req_t        req;
  logic [7:0]      rdata_ff;
  logic            rvalid_ff;
  sync_primary_t   sync_pri;
  sync_secondary_t sync_sec;
  logic [6:0]      evt_src;
  logic [2:0]      mon_val;
  logic [1:0]      drift_range_ff;
  logic            irq_ff;
  int              errors;
  int              check_count;

  sync_status_and_irq_regs dut_u (.clk(clk), .sys_rst(sys_rst), .req(req),
    .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff), .sync_pri(sync_pri), .sync_sec(sync_sec),
    .evt_src(evt_src), .mon_val(mon_val), .drift_range_ff(drift_range_ff), .irq_ff(irq_ff));

  // Free-running 50 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  // Each access waits an edge first, so a request is never raised in the step it fell.
  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1 req = '0;
  endtask : reg_wr

  task automatic reg_rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1 req = '0;
    chk1(rvalid_ff, 1'b1);
    chk8(rdata_ff, e);
  endtask : reg_rd

  // Waits a bounded time for the interrupt level; running out ends the run.
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq_ff !== lvl && n < 8)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk1(irq_ff, lvl);
    if (n == 8)
      complete_run();
  endtask : wait_irq

  task automatic status_regs;
    sync_pri = 8'hA5;
    reg_rd(7'h09, 8'hA5);
    sync_pri = 8'h5A;
    reg_wr(7'h09, 8'hFF);
    reg_rd(7'h09, 8'h5A);
    sync_sec = 8'hFF;
    reg_rd(7'h0a, 8'h3F);
    for (int p = 0; p < 4; p++)
    begin
      sync_sec = 8'(p << 3) | 8'h04;
      reg_wr(7'h0a, 8'h20);
      reg_rd(7'h0a, 8'(p << 3) | 8'h04);
    end
  endtask : status_regs

  task automatic cfg_regs;
    reg_rd(7'h0b, 8'h00);
    reg_rd(7'h0c, 8'h00);
    reg_wr(7'h0b, 8'h0E);
    reg_rd(7'h0b, 8'h0E);
    chk8({6'h00, drift_range_ff}, 8'h02);
    reg_wr(7'h0c, 8'hA5);
    reg_rd(7'h0c, 8'hA5);
    reg_wr(7'h0d, 8'hFF);
    reg_rd(7'h0d, 8'h00);
    reg_rd(7'h20, 8'h00);
    reg_wr(7'h0b, 8'h00);
  endtask : cfg_regs

  // Events pulse and drop before any read, so set-over-clear never hides clearance.
  task automatic irq_gate;
    reg_wr(7'h0c, 8'hFF);
    evt_src = 7'h7F;
    repeat (2) @(posedge clk);
    #1 evt_src = 7'h00;
    repeat (4) @(posedge clk);
    #1 chk1(irq_ff, 1'b0);
    reg_rd(7'h0d, 8'hFE);
    reg_rd(7'h0d, 8'hFE);
    reg_wr(7'h0b, 8'h08);
    wait_irq(1'b1);
    reg_rd(7'h0d, 8'hFE);
    reg_rd(7'h0d, 8'h00);
    wait_irq(1'b0);
    reg_wr(7'h0c, 8'h7F);
    evt_src = 7'h40;
    repeat (2) @(posedge clk);
    #1 evt_src = 7'h00;
    repeat (4) @(posedge clk);
    #1 chk1(irq_ff, 1'b0);
    reg_rd(7'h0d, 8'h80);
  endtask : irq_gate

  // Sweeps every drift threshold code against monitor positions 1 to 5.
  task automatic drift_codes;
    logic hit;
    for (int c = 0; c < 4; c++)
      for (int m = 1; m < 6; m++)
      begin
        hit = (c == 0 && (m == 1 || m == 5)) || (c == 1 && (m == 2 || m == 4));
        hit = hit || (c == 2 && m == 3);
        reg_wr(7'h0b, 8'h08 | 8'(c));
        mon_val = 3'(m);
        repeat (3) @(posedge clk);
        #1 mon_val = 3'h0;
        chk8({6'h00, drift_range_ff}, 8'(c));
        repeat (3) @(posedge clk);
        reg_rd(7'h0d, {7'h00, hit});
      end
  endtask : drift_codes

  // Reset, then each scenario in turn.
  initial
  begin
    errors = 0;
    check_count = 0;
    sys_rst = 1'b1;
    req = '0;
    sync_pri = '0;
    sync_sec = '0;
    evt_src = 7'h00;
    mon_val = 3'h0;
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk1(irq_ff, 1'b0);
    status_regs();
    cfg_regs();
    irq_gate();
    drift_codes();
    complete_run();
  end
endmodule : sync_status_and_irq_regs_tb
`default_nettype wire
